/* File: common/osx_pkg.sv */
// Package of constants and types for the OR, special-page and branch unit
package osx_pkg;
  // ****************************************************
  // Widths and vectors
  // ****************************************************
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int RAM_AW = 7;
  localparam int SPG_IDX_W = 4;
  localparam logic [10:0] TRAP_VECTOR = 11'h001;
  localparam logic [3:0] SPG_IDX_MIN = 4'h5;
  localparam logic [3:0] SPG_IDX_MAX = 4'hf;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [7:0] SPG_RESET = 8'h00;
  // ****************************************************
  // Cycle counts
  // ****************************************************
  localparam logic [1:0] TRAP_CYCLES = 2'h3;
  localparam logic [1:0] JUMP_CYCLES = 2'h2;
  localparam logic [1:0] ONE_CYCLE = 2'h1;

  typedef enum logic [5:0] {
    OSX_OP_NONE = 6'h01,
    OSX_OP_TRAP = 6'h02,
    OSX_OP_OR_IMM = 6'h04,
    OSX_OP_OR_REG = 6'h08,
    OSX_OP_SPG_ST = 6'h10,
    OSX_OP_SPG_LD = 6'h20
  } osx_op_t;

  typedef struct packed {
    logic valid;
    osx_op_t op;
    logic long_jump;
    logic [7:0] imm;
    logic [6:0] addr;
    logic dest;
    logic [3:0] spg_idx;
    logic [10:0] target;
  } osx_cmd_t;

  typedef struct packed {
    logic push;
    logic [10:0] push_addr;
    logic ram_we;
    logic [6:0] ram_addr;
    logic [7:0] ram_wdata;
  } osx_mem_t;
endpackage : osx_pkg

/* File: hdl/osx_spage.sv */
// Second special-function page register array
`timescale 1ns/10ps
module osx_spage #(
  parameter int IDX_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_we,
  input wire logic [IDX_W-1:0] i_idx,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import osx_pkg::*;
  logic [7:0] mem_r [0:(1<<IDX_W)-1];
  logic [7:0] mem_nxt [0:(1<<IDX_W)-1];

  generate
    if (IDX_W != SPG_IDX_W) begin : g_bad_idx_width
      $error("osx_spage: index width unsupported");
    end
  endgenerate

  // ****************************************************
  // One register per index
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < (1<<IDX_W); g++) begin : g_reg
      always_comb begin
        mem_nxt[g] = mem_r[g];
        if (i_we && (i_idx == IDX_W'(g)) && (IDX_W'(g) >= SPG_IDX_MIN)) begin
          mem_nxt[g] = i_wdata;
        end
      end
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          mem_r[g] <= SPG_RESET;
        end else begin
          mem_r[g] <= mem_nxt[g];
        end
      end
    end
  endgenerate

  // Indices below the page window read as zero
  assign o_rdata = (i_idx >= SPG_IDX_MIN) ? mem_r[i_idx] : 8'h00;
endmodule : osx_spage

/* File: hdl/osx_exec.sv */
// Execution unit for trap, OR, special-page move and long jump
//
// Overview of operation
// - Trap pushes the next address, loads vector 0x001, takes three cycles.
// - Immediate OR writes the accumulator, updates zero, takes one cycle.
// - Memory OR of byte 0..127 writes accumulator or byte, in one cycle.
// - Page store copies the accumulator to page register 5..15, flags kept.
// - Page load copies page register 5..15 to the accumulator, flags kept.
// - Long jump loads the 11-bit target into the pc and takes two cycles.
`timescale 1ns/10ps
module osx_exec #(
  parameter int PC_WIDTH = 11
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire osx_pkg::osx_cmd_t I_CMD,
  input wire logic [7:0] I_RAM_RDATA,
  output logic O_READY,
  output osx_pkg::osx_mem_t O_MEM,
  output logic [PC_WIDTH-1:0] O_PC,
  output logic [7:0] O_ACCUMULATOR,
  output logic O_ZERO
);
  import osx_pkg::*;

  // ****************************************************
  // Parameter check
  // ****************************************************
  generate
    if (PC_WIDTH != PC_W) begin : g_bad_pc_width
      $error("osx_exec: program counter width unsupported");
    end
  endgenerate

  typedef enum logic [2:0] {
    OSX_ST_IDLE = 3'h1,
    OSX_ST_BUSY = 3'h2,
    OSX_ST_LAST = 3'h4
  } osx_state_t;

  // ****************************************************
  // Declarations
  // ****************************************************
  osx_state_t state_r;
  osx_state_t state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [10:0] pc_r;
  logic [10:0] pc_nxt;
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic zero_r;
  logic zero_nxt;
  osx_mem_t mem_r;
  osx_mem_t mem_nxt;
  logic take;
  logic op_take;
  logic is_trap;
  logic is_or_imm;
  logic is_or_reg;
  logic is_spg_st;
  logic is_spg_ld;
  logic spg_in_page;
  logic spg_we;
  logic [7:0] spg_rdata;
  logic [7:0] or_res;

  // ****************************************************
  // Decode
  // ****************************************************
  assign take = I_CMD.valid && (state_r == OSX_ST_IDLE);
  assign op_take = take && !I_CMD.long_jump;
  assign is_trap = op_take && (I_CMD.op == OSX_OP_TRAP);
  assign is_or_imm = op_take && (I_CMD.op == OSX_OP_OR_IMM);
  assign is_or_reg = op_take && (I_CMD.op == OSX_OP_OR_REG);
  assign is_spg_st = op_take && (I_CMD.op == OSX_OP_SPG_ST);
  assign is_spg_ld = op_take && (I_CMD.op == OSX_OP_SPG_LD);
  assign spg_in_page = (I_CMD.spg_idx >= SPG_IDX_MIN);
  assign spg_we = is_spg_st && spg_in_page;

  // OR operand select
  always_comb begin
    or_res = acc_r | I_CMD.imm;
    if (is_or_reg) begin
      or_res = acc_r | I_RAM_RDATA;
    end
  end

  // ****************************************************
  // Special-function page
  // ****************************************************
  osx_spage #(
    .IDX_W(SPG_IDX_W)
  ) u_spage (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_we(spg_we),
    .i_idx(I_CMD.spg_idx),
    .i_wdata(acc_r),
    .o_rdata(spg_rdata)
  );

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      OSX_ST_IDLE: begin
        if (take && I_CMD.long_jump) begin
          cnt_nxt = JUMP_CYCLES - 2'h1;
          state_nxt = OSX_ST_LAST;
        end else if (is_trap) begin
          cnt_nxt = TRAP_CYCLES - 2'h1;
          state_nxt = OSX_ST_BUSY;
        end
      end
      OSX_ST_BUSY: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h2) begin
          state_nxt = OSX_ST_LAST;
        end
      end
      OSX_ST_LAST: begin
        cnt_nxt = 2'h0;
        state_nxt = OSX_ST_IDLE;
      end
      default: begin
        cnt_nxt = 2'h0;
        state_nxt = OSX_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_r <= OSX_ST_IDLE;
      cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************************
  // Program counter
  // ****************************************************
  always_comb begin
    pc_nxt = pc_r;
    if (take) begin
      if (I_CMD.long_jump) begin
        pc_nxt = I_CMD.target;
      end else if (is_trap) begin
        pc_nxt = TRAP_VECTOR;
      end else begin
        pc_nxt = pc_r + 11'h001;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pc_r <= PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // ****************************************************
  // Accumulator and zero flag
  // ****************************************************
  always_comb begin
    acc_nxt = acc_r;
    zero_nxt = zero_r;
    if (is_or_imm) begin
      acc_nxt = or_res;
      zero_nxt = (or_res == 8'h00);
    end else if (is_or_reg) begin
      zero_nxt = (or_res == 8'h00);
      if (!I_CMD.dest) begin
        acc_nxt = or_res;
      end
    end else if (is_spg_ld && spg_in_page) begin
      acc_nxt = spg_rdata;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      acc_r <= ACC_RESET;
      zero_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      zero_r <= zero_nxt;
    end
  end

  // ****************************************************
  // Stack and data memory pulses
  // ****************************************************
  always_comb begin
    mem_nxt = '0;
    if (is_trap) begin
      mem_nxt.push = 1'b1;
      mem_nxt.push_addr = pc_r + 11'h001;
    end
    if (is_or_reg && I_CMD.dest) begin
      mem_nxt.ram_we = 1'b1;
      mem_nxt.ram_addr = I_CMD.addr;
      mem_nxt.ram_wdata = or_res;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign O_READY = (state_r == OSX_ST_IDLE);
  assign O_MEM = mem_r;
  assign O_PC = pc_r;
  assign O_ACCUMULATOR = acc_r;
  assign O_ZERO = zero_r;
endmodule : osx_exec

/* File: tb/osx_exec_props.sv */
// Checker of the execution unit ports
`timescale 1ns/10ps
module osx_exec_props #(
  parameter int PC_WIDTH = 11
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire osx_pkg::osx_cmd_t i_cmd,
  input wire logic [7:0] i_ram_rdata,
  input wire logic o_ready,
  input wire osx_pkg::osx_mem_t o_mem,
  input wire logic [PC_WIDTH-1:0] o_pc,
  input wire logic [7:0] o_accumulator,
  input wire logic o_zero
);
  import osx_pkg::*;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  logic tk;
  assign tk = i_cmd.valid && o_ready && !i_cmd.long_jump;
  // ****************************************************
  // Assertions
  // ****************************************************
  a_trap_vector: assert property (tk && i_cmd.op == OSX_OP_TRAP |=>
    o_pc == TRAP_VECTOR && o_mem.push && !o_ready &&
    o_mem.push_addr == $past(o_pc) + 11'h001 ##1 !o_ready ##1 o_ready)
    else $error("trap sequence wrong");
  a_or_imm: assert property (tk && i_cmd.op == OSX_OP_OR_IMM |=>
    o_accumulator == ($past(o_accumulator) | $past(i_cmd.imm)) && o_ready)
    else $error("immediate or wrong");
  a_or_acc: assert property (tk && i_cmd.op == OSX_OP_OR_REG &&
    !i_cmd.dest |=> !o_mem.ram_we &&
    o_accumulator == ($past(o_accumulator) | $past(i_ram_rdata)))
    else $error("register or to accumulator wrong");
  a_or_mem: assert property (tk && i_cmd.op == OSX_OP_OR_REG &&
    i_cmd.dest |=> o_mem.ram_we && $stable(o_accumulator) &&
    o_mem.ram_addr == $past(i_cmd.addr) &&
    o_mem.ram_wdata == ($past(o_accumulator) | $past(i_ram_rdata)))
    else $error("register or to memory wrong");
  a_store_flags: assert property (tk && i_cmd.op == OSX_OP_SPG_ST |=>
    $stable(o_zero) && $stable(o_accumulator) && !o_mem.ram_we)
    else $error("page store changed state");
  a_load_flags: assert property (tk && i_cmd.op == OSX_OP_SPG_LD |=>
    $stable(o_zero))
    else $error("page load changed zero flag");
  a_long_jump: assert property (i_cmd.valid && o_ready &&
    i_cmd.long_jump |=> o_pc == $past(i_cmd.target) && !o_ready ##1 o_ready)
    else $error("long jump wrong");
  a_zero_flag: assert property (tk && (i_cmd.op == OSX_OP_OR_IMM ||
    i_cmd.op == OSX_OP_OR_REG) |=> o_zero ==
    ((o_mem.ram_we ? o_mem.ram_wdata : o_accumulator) == 8'h00))
    else $error("zero flag wrong");
  c_trap: cover property (tk && i_cmd.op == OSX_OP_TRAP);
  c_jump: cover property (i_cmd.valid && o_ready && i_cmd.long_jump);
  c_or_mem: cover property (tk && i_cmd.op == OSX_OP_OR_REG && i_cmd.dest);
endmodule : osx_exec_props

bind osx_exec osx_exec_props #(
  .PC_WIDTH(PC_WIDTH)
) i_osx_exec_props (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RST_B(I_RST_B),
  .i_cmd(I_CMD),
  .i_ram_rdata(I_RAM_RDATA),
  .o_ready(O_READY),
  .o_mem(O_MEM),
  .o_pc(O_PC),
  .o_accumulator(O_ACCUMULATOR),
  .o_zero(O_ZERO)
);

/* File: tb/tb_top.sv */
// Testbench of the execution unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import osx_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  osx_cmd_t cmd = '0;
  logic [7:0] rdata = 8'h00;
  logic rdy;
  osx_mem_t mem;
  logic [10:0] pc;
  logic [7:0] acc;
  logic zf;
  int err_total = 0;
  int n_tests = 0;
  osx_exec i_osx_exec (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_CMD(cmd),
    .I_RAM_RDATA(rdata), .O_READY(rdy), .O_MEM(mem), .O_PC(pc),
    .O_ACCUMULATOR(acc), .O_ZERO(zf));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic run(osx_op_t op, logic lj, logic [7:0] im, logic [6:0] ad,
    logic d, logic [3:0] ix, logic [10:0] tg, logic [7:0] rd);
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (rdy !== 1'b1) begin
      err_total++;
      wrap_up();
    end
    @(posedge clk);
    cmd <= '{1'b1, op, lj, im, ad, d, ix, tg};
    rdata <= rd;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask : run
  task automatic t_or();
    run(OSX_OP_OR_IMM, '0, 8'h00, '0, '0, '0, '0, '0);
    `CHK("zero", 1'b1, zf)
    run(OSX_OP_OR_IMM, '0, 8'ha0, '0, '0, '0, '0, '0);
    `CHK("acc", 8'ha0, acc)
    `CHK("zero", 1'b0, zf)
    run(OSX_OP_OR_REG, '0, '0, 7'h7f, 1'b0, '0, '0, 8'h0a);
    `CHK("acc", 8'haa, acc)
    run(OSX_OP_OR_REG, '0, '0, 7'h2a, 1'b1, '0, '0, 8'h50);
    `CHK("we", 1'b1, mem.ram_we)
    `CHK("waddr", 7'h2a, mem.ram_addr)
    `CHK("wdata", 8'hfa, mem.ram_wdata)
    `CHK("acc", 8'haa, acc)
    `CHK("pc", 11'h004, pc)
    $display("done or");
  endtask : t_or
  task automatic t_spg();
    run(OSX_OP_SPG_ST, '0, '0, '0, '0, 4'hf, '0, '0);
    run(OSX_OP_SPG_ST, '0, '0, '0, '0, 4'h4, '0, '0);
    run(OSX_OP_SPG_LD, '0, '0, '0, '0, 4'h5, '0, '0);
    `CHK("acc", 8'h00, acc)
    `CHK("zero", 1'b0, zf)
    run(OSX_OP_SPG_LD, '0, '0, '0, '0, 4'h4, '0, '0);
    `CHK("acc", 8'h00, acc)
    run(OSX_OP_SPG_LD, '0, '0, '0, '0, 4'hf, '0, '0);
    `CHK("acc", 8'haa, acc)
    $display("done spg");
  endtask : t_spg
  task automatic t_br();
    run(OSX_OP_NONE, 1'b1, '0, '0, '0, '0, 11'h7ff, '0);
    `CHK("pc", 11'h7ff, pc)
    `CHK("rdy", 1'b0, rdy)
    run(OSX_OP_TRAP, '0, '0, '0, '0, '0, '0, '0);
    `CHK("pc", 11'h001, pc)
    `CHK("push", 1'b1, mem.push)
    `CHK("ret", 11'h000, mem.push_addr)
    @(posedge clk);
    #1;
    `CHK("rdy", 1'b0, rdy)
    @(posedge clk);
    #1;
    `CHK("rdy", 1'b1, rdy)
    $display("done branch");
  endtask : t_br
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_or();
    t_spg();
    t_br();
    wrap_up();
  end
endmodule : tb_top
